/* core/oag_core.sv */
// operand addressing: byte count and effective address per mode
// Functional notes
// - inherent: opcode only, no further bytes
// - immediate: opcode plus one operand byte
// - short direct: one byte address 00-FF
// - long direct: two byte address word
// - indexed: unsigned index plus offset
// - no offset indexed: address is index
// - short indexed: byte offset, reach 1FE
// - long indexed: word offset, full space
// - indirect: fetch pointer, then operand address
// - short indirect: byte pointer, page zero
// - long indirect: word pointer, full space
// - relative: signed offset on next pc
// - short direct and short indirect stay in page zero; short indexed reaches 1FE
// - read-modify-write refuses the long forms (direct, indexed, indirect)
// - no offset: alternate index adds one byte
`timescale 1ns/1ps
module oag_core
   import oag_pkg::*;
(
   input  wire logic        sys_clk,   // core clock 50 MHz
   input  wire logic        rst,       // async reset, high
   input  wire logic        op_valid,  // opcode presented
   output logic             op_ready,  // decoder idle
   input  wire oag_mode_t   op_mode,   // addressing mode
   input  wire logic        op_alt,    // alternate index selected
   input  wire logic        op_rmw,    // read-modify-write opcode
   input  wire logic [7:0]  idx_pri,   // primary index value
   input  wire logic [7:0]  idx_alt,   // alternate index value
   input  wire logic [15:0] pc_next,   // pc past the instruction
   output logic             fb_req,    // request next stream byte
   input  wire logic        fb_valid,  // stream byte present
   input  wire logic [7:0]  fb_data,   // stream byte
   output logic             mem_req,   // pointer read request
   output logic [15:0]      mem_addr,  // pointer read address
   input  wire logic        mem_valid, // pointer byte returned
   input  wire logic [7:0]  mem_data,  // pointer byte
   output logic             ea_valid,  // address ready pulse
   output logic [15:0]      ea_addr,   // effective address
   output logic [7:0]       ea_imm,    // immediate operand
   output logic             ea_is_imm, // operand is immediate
   output logic [1:0]       ea_len,    // bytes after opcode
   output logic             ea_err     // mode refused for opcode
);
   typedef enum {
      OAG_IDLE, OAG_FETCH, OAG_PTR, OAG_DONE
   } oag_state_t;

   oag_state_t  state_ff, nxt_state;
   oag_mode_t   mode_ff;
   logic        alt_ff;
   logic [1:0]  need_ff;
   logic [1:0]  pneed_ff;
   logic [1:0]  pcnt_ff;
   logic [15:0] ptr_ff;
   logic [15:0] addr_ff;
   logic [7:0]  imm_ff;
   logic        isimm_ff;
   logic        err_ff;
   logic [1:0]  len_ff;

   oag_fetch_if fif ();
   oag_byte_asm u_asm (
      .sys_clk (sys_clk),
      .rst     (rst),
      .f       (fif)
   );

   // stream bytes after the opcode per mode
   logic [1:0] need_w;
   always_comb begin
      unique case (op_mode)
         OAG_M_INH:   need_w = 2'h0;
         OAG_M_IMM:   need_w = 2'h1;
         OAG_M_DIR_S: need_w = 2'h1;
         OAG_M_DIR_L: need_w = 2'h2;
         OAG_M_IDX_N: need_w = op_alt ? 2'h1 : 2'h0;
         OAG_M_IDX_S: need_w = 2'h1;
         OAG_M_IDX_L: need_w = 2'h2;
         OAG_M_IND_S: need_w = 2'h1;
         OAG_M_IND_L: need_w = 2'h1;
         OAG_M_REL_D: need_w = 2'h1;
         OAG_M_REL_I: need_w = 2'h1;
         OAG_M_BIT_D: need_w = 2'h1;
         OAG_M_BIT_I: need_w = 2'h1;
         OAG_M_BTR_D: need_w = 2'h2;
         OAG_M_BTR_I: need_w = 2'h2;
         default:     need_w = 2'h0;
      endcase
   end

   // pointer bytes read from memory
   wire [1:0] pneed_w =
      (op_mode == OAG_M_IND_L) ? 2'h2 :
      (op_mode == OAG_M_IND_S || op_mode == OAG_M_REL_I ||
       op_mode == OAG_M_BIT_I || op_mode == OAG_M_BTR_I) ? 2'h1 : 2'h0;

   // long forms refused for read-modify-write opcodes
   wire long_w = (op_mode == OAG_M_DIR_L) || (op_mode == OAG_M_IDX_L) ||
                 (op_mode == OAG_M_IND_L);
   wire rmw_bad = op_rmw && long_w;

   wire [7:0]  idx_w    = alt_ff ? idx_alt : idx_pri;
   wire [15:0] idx16    = {8'h00, idx_w};
   wire [15:0] wd       = fif.word;
   wire [15:0] off8     = {8'h00, wd[7:0]};
   wire [15:0] rel_off  = {{8{wd[7]}}, wd[7:0]};
   wire [15:0] prel_off = {{8{ptr_ff[7]}}, ptr_ff[7:0]};
   wire [15:0] ptr_base = {8'h00, wd[7:0]};
   // bit-relative: first stream byte is the address, second the offset
   wire [15:0] btr_adr  = {8'h00, wd[15:8]};

   // effective address once all bytes are in hand
   logic [15:0] ea_w;
   always_comb begin
      unique case (mode_ff)
         OAG_M_DIR_S: ea_w = off8;
         OAG_M_DIR_L: ea_w = wd;
         OAG_M_IDX_N: ea_w = idx16;
         OAG_M_IDX_S: ea_w = idx16 + off8;
         OAG_M_IDX_L: ea_w = idx16 + wd;
         OAG_M_IND_S: ea_w = {8'h00, ptr_ff[7:0]};
         OAG_M_IND_L: ea_w = ptr_ff;
         OAG_M_REL_D: ea_w = pc_next + rel_off;
         OAG_M_REL_I: ea_w = pc_next + prel_off;
         OAG_M_BIT_D: ea_w = off8;
         OAG_M_BIT_I: ea_w = {8'h00, ptr_ff[7:0]};
         OAG_M_BTR_D: ea_w = btr_adr;
         OAG_M_BTR_I: ea_w = {8'h00, ptr_ff[7:0]};
         default:     ea_w = OAG_ADDR_RST;
      endcase
   end

   // pointer location for indirect reads
   wire [15:0] ptr_loc  = ((mode_ff == OAG_M_BTR_I) ? btr_adr : ptr_base)
                          + {14'h0000, pcnt_ff};
   wire fetch_done = (fif.count == need_ff);
   wire ptr_done   = (pcnt_ff == pneed_ff);
   wire take_w     = (state_ff == OAG_FETCH) && !fetch_done && fb_valid;
   wire start_w    = (state_ff == OAG_IDLE) && op_valid;
   wire pget_w     = (state_ff == OAG_PTR) && !ptr_done && mem_valid;

   assign fif.take = take_w;
   assign fif.data = fb_data;
   assign fif.clr  = start_w;

   always_comb begin
      nxt_state = state_ff;
      unique case (state_ff)
         OAG_IDLE:  if (op_valid) nxt_state = OAG_FETCH;
         OAG_FETCH: if (fetch_done)
                       nxt_state = (pneed_ff != 2'h0) ? OAG_PTR : OAG_DONE;
         OAG_PTR:   if (ptr_done) nxt_state = OAG_DONE;
         OAG_DONE:  nxt_state = OAG_IDLE;
      endcase
   end

   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         state_ff <= OAG_IDLE;
         mode_ff  <= OAG_M_INH;
         alt_ff   <= 1'b0;
         need_ff  <= OAG_CNT_RST;
         pneed_ff <= OAG_CNT_RST;
         len_ff   <= OAG_CNT_RST;
         err_ff   <= 1'b0;
      end else begin
         state_ff <= nxt_state;
         if (start_w) begin
            mode_ff  <= op_mode;
            alt_ff   <= op_alt;
            need_ff  <= need_w;
            pneed_ff <= pneed_w;
            len_ff   <= need_w;
            err_ff   <= rmw_bad;
         end
      end
   end

   // pointer collection, high byte first
   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         ptr_ff  <= OAG_ADDR_RST;
         pcnt_ff <= OAG_CNT_RST;
      end else if (start_w) begin
         ptr_ff  <= OAG_ADDR_RST;
         pcnt_ff <= OAG_CNT_RST;
      end else if (pget_w) begin
         ptr_ff  <= {ptr_ff[7:0], mem_data};
         pcnt_ff <= pcnt_ff + 2'h1;
      end
   end

   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         addr_ff  <= OAG_ADDR_RST;
         imm_ff   <= OAG_BYTE_RST;
         isimm_ff <= 1'b0;
      end else if (state_ff == OAG_DONE) begin
         addr_ff  <= ea_w;
         imm_ff   <= wd[7:0];
         isimm_ff <= (mode_ff == OAG_M_IMM);
      end
   end

   logic valid_ff;
   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) valid_ff <= 1'b0;
      else     valid_ff <= (state_ff == OAG_DONE);
   end

   assign op_ready  = (state_ff == OAG_IDLE);
   assign fb_req    = (state_ff == OAG_FETCH) && !fetch_done;
   assign mem_req   = (state_ff == OAG_PTR) && !ptr_done;
   assign mem_addr  = ptr_loc;
   assign ea_valid  = valid_ff;
   assign ea_addr   = addr_ff;
   assign ea_imm    = imm_ff;
   assign ea_is_imm = isimm_ff;
   assign ea_len    = len_ff;
   assign ea_err    = err_ff;

   sequence s_start_inh;
      start_w && op_mode == OAG_M_INH;
   endsequence
   sequence s_start_long;
      start_w && op_mode == OAG_M_DIR_L;
   endsequence

   a_inh_no_fetch: assert property (@(posedge sys_clk) disable iff (rst)
      s_start_inh |=> !fb_req ##1 !fb_req && valid_ff == 1'b0)
      else $error("inherent fetched a byte");
   a_long_len: assert property (@(posedge sys_clk) disable iff (rst)
      s_start_long |=> need_ff == 2'h2)
      else $error("long direct length wrong");
   a_imm_len: assert property (@(posedge sys_clk) disable iff (rst)
      start_w && op_mode == OAG_M_IMM |=> len_ff == 2'h1)
      else $error("immediate length wrong");
   a_short_dir: assert property (@(posedge sys_clk) disable iff (rst)
      valid_ff && mode_ff == OAG_M_DIR_S |-> ea_addr[15:8] == 8'h00)
      else $error("short direct left page zero");
   a_idx_short: assert property (@(posedge sys_clk) disable iff (rst)
      valid_ff && mode_ff == OAG_M_IDX_S |-> ea_addr <= 16'h01FE)
      else $error("short indexed out of range");
   a_ind_page: assert property (@(posedge sys_clk) disable iff (rst)
      valid_ff && mode_ff == OAG_M_IND_S |-> ea_addr[15:8] == 8'h00)
      else $error("short indirect left page zero");
   a_idx_noofs: assert property (@(posedge sys_clk) disable iff (rst)
      start_w && op_mode == OAG_M_IDX_N && !op_alt |=> need_ff == 2'h0)
      else $error("no offset indexed fetched byte");
   a_rmw_long: assert property (@(posedge sys_clk) disable iff (rst)
      start_w && op_rmw && op_mode == OAG_M_IDX_L |=> ea_err)
      else $error("long form accepted for rmw");
   a_bytes_first: assert property (@(posedge sys_clk) disable iff (rst)
      state_ff == OAG_PTR |-> fif.count == need_ff)
      else $error("pointer read before bytes fetched");
endmodule

/* inc/oag_pkg.sv */
// shared constants and types for the operand address generator
package oag_pkg;
   localparam int OAG_AW = 16;
   localparam int OAG_DW = 8;
   localparam logic [15:0] OAG_ADDR_RST = 16'h0000;
   localparam logic [7:0] OAG_BYTE_RST = 8'h00;
   localparam logic [1:0] OAG_CNT_RST = 2'h0;

   // addressing modes as presented by the opcode decoder
   typedef enum logic [3:0] {
      OAG_M_INH      = 4'h0,
      OAG_M_IMM      = 4'h1,
      OAG_M_DIR_S    = 4'h2,
      OAG_M_DIR_L    = 4'h3,
      OAG_M_IDX_N    = 4'h4,
      OAG_M_IDX_S    = 4'h5,
      OAG_M_IDX_L    = 4'h6,
      OAG_M_IND_S    = 4'h7,
      OAG_M_IND_L    = 4'h8,
      OAG_M_REL_D    = 4'h9,
      OAG_M_REL_I    = 4'hA,
      OAG_M_BIT_D    = 4'hB,
      OAG_M_BIT_I    = 4'hC,
      OAG_M_BTR_D    = 4'hD,
      OAG_M_BTR_I    = 4'hE
   } oag_mode_t;
endpackage

/* inc/oag_fetch_if.sv */
// fetch byte stream between sequencer and byte assembler
`timescale 1ns/1ps
interface oag_fetch_if;
   logic       take;
   logic [7:0] data;
   logic       clr;
   logic [1:0] count;
   logic [15:0] word;
   modport seq (output take, output data, output clr,
                input count, input word);
   modport asm (input take, input data, input clr,
                output count, output word);
endinterface

/* core/oag_byte_asm.sv */
// assembles operand bytes that follow the opcode, high byte first
`timescale 1ns/1ps
module oag_byte_asm
   import oag_pkg::*;
(
   input  wire logic sys_clk, // core clock
   input  wire logic rst,     // async reset
   oag_fetch_if.asm  f        // byte stream
);
   logic [15:0] word_ff;
   logic [1:0]  count_ff;
   wire  [15:0] nxt_word  = {word_ff[7:0], f.data};
   wire  [1:0]  nxt_count = count_ff + 2'h1;

   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         word_ff  <= OAG_ADDR_RST;
         count_ff <= OAG_CNT_RST;
      end else if (f.clr) begin
         word_ff  <= OAG_ADDR_RST;
         count_ff <= OAG_CNT_RST;
      end else if (f.take) begin
         word_ff  <= nxt_word;
         count_ff <= nxt_count;
      end
   end

   assign f.count = count_ff;
   assign f.word  = word_ff;
endmodule

/* test/oag_partner.sv */
// fetch stream and 512-byte memory model facing the core
`timescale 1ns/1ps
module oag_partner
   import oag_pkg::*;
(
   input  wire logic        sys_clk,   // core clock
   input  wire logic        rst,       // async reset
   input  wire logic        slow,      // answer on alternate cycles
   input  wire logic        fb_req,    // byte wanted
   output logic             fb_valid,  // byte present
   output logic [7:0]       fb_data,   // stream byte
   input  wire logic        mem_req,   // pointer read
   input  wire logic [15:0] mem_addr,  // pointer location
   output logic             mem_valid, // pointer byte present
   output logic [7:0]       mem_data   // pointer byte
);
   logic [7:0] q[$];
   logic [7:0] mem [0:511];
   logic       wait_ff;
   always @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         fb_valid <= 1'h0;
         fb_data <= 8'h00;
         mem_valid <= 1'h0;
         mem_data <= 8'h00;
         wait_ff <= 1'h0;
      end else begin
         wait_ff <= slow & ~wait_ff;
         // released lines show the inverse, never the stale byte
         if (fb_req && fb_valid) begin
            void'(q.pop_front());
            fb_valid <= 1'h0;
            fb_data <= ~fb_data;
         end else if (fb_req && q.size() > 0 && !wait_ff) begin
            fb_valid <= 1'h1;
            fb_data <= q[0];
         end
         if (mem_req && mem_valid) begin
            mem_valid <= 1'h0;
            mem_data <= ~mem_data;
         end else if (mem_req && !wait_ff) begin
            mem_valid <= 1'h1;
            mem_data <= mem[mem_addr[8:0]];
         end
      end
   end
endmodule

/* test/tb_operand_address_generator.sv */
// self-checking bench for the operand address generator
`timescale 1ns/1ps
module tb_operand_address_generator
   import oag_pkg::*;
;
   logic sys_clk, rst, op_valid, op_ready, op_alt, op_rmw, slow;
   oag_mode_t op_mode;
   logic [7:0] idx_pri, idx_alt, fb_data, mem_data, ea_imm;
   logic [15:0] pc_next, mem_addr, ea_addr;
   logic fb_req, fb_valid, mem_req, mem_valid, ea_valid, ea_is_imm, ea_err;
   logic [1:0] ea_len;
   int n_mismatch = 0;
   int n_tests = 0;

   oag_core dut (.sys_clk, .rst, .op_valid, .op_ready, .op_mode, .op_alt,
      .op_rmw, .idx_pri, .idx_alt, .pc_next, .fb_req, .fb_valid, .fb_data,
      .mem_req, .mem_addr, .mem_valid, .mem_data, .ea_valid, .ea_addr,
      .ea_imm, .ea_is_imm, .ea_len, .ea_err);
   oag_partner p (.sys_clk, .rst, .slow, .fb_req, .fb_valid, .fb_data,
      .mem_req, .mem_addr, .mem_valid, .mem_data);

   initial sys_clk = 1'h0;
   always #10 sys_clk = ~sys_clk;

   task automatic stop_test;
      $display("tests=%0d mismatches=%0d", n_tests, n_mismatch);
      if (n_mismatch == 0 && n_tests > 0)
         $display("TB: PASS");
      else
         $display("TB: FAIL");
      $finish;
   endtask

   task automatic chk(input logic [15:0] g, input logic [15:0] e);
      n_tests++;
      if (g !== e) begin
         n_mismatch++;
         $display("MISMATCH t=%0t got=%h exp=%h", $time, g, e);
      end
   endtask

   // one opcode; exact asks that every queued byte was consumed
   task automatic op(input oag_mode_t m, input logic alt, input logic rmw,
                     input logic exact);
      int n;
      n = 0;
      @(negedge sys_clk);
      op_mode = m;
      op_alt = alt;
      op_rmw = rmw;
      op_valid = 1'h1;
      @(negedge sys_clk);
      op_valid = 1'h0;
      while (ea_valid !== 1'h1 && n < 100) begin
         @(negedge sys_clk);
         n++;
      end
      chk(16'(ea_valid), 16'h0001);
      if (exact)
         chk(16'(p.q.size()), 16'h0000);
      p.q.delete();
   endtask

   task automatic res(input logic [15:0] a, input logic [1:0] l);
      chk(ea_addr, a);
      chk(16'(ea_len), 16'(l));
   endtask

   task automatic t_inh_imm;
      op(OAG_M_INH, 1'h0, 1'h0, 1'h1);
      chk(16'(ea_len), 16'h0000);
      p.q = '{8'hA5};
      op(OAG_M_IMM, 1'h0, 1'h0, 1'h1);
      chk({ea_is_imm, 7'h00, ea_imm}, 16'h80A5);
      chk(16'(ea_len), 16'h0001);
   endtask

   task automatic t_direct;
      p.q = '{8'hFF};
      op(OAG_M_DIR_S, 1'h0, 1'h0, 1'h1);
      res(16'h00FF, 2'h1);
      chk(16'(ea_is_imm), 16'h0000);
      p.q = '{8'h12, 8'h34};
      op(OAG_M_DIR_L, 1'h0, 1'h0, 1'h1);
      res(16'h1234, 2'h2);
   endtask

   task automatic t_indexed;
      idx_pri = 8'hFF;
      idx_alt = 8'h10;
      op(OAG_M_IDX_N, 1'h0, 1'h0, 1'h1);
      res(16'h00FF, 2'h0);
      p.q = '{8'h00};
      op(OAG_M_IDX_N, 1'h1, 1'h0, 1'h1);
      res(16'h0010, 2'h1);
      p.q = '{8'hFF};
      op(OAG_M_IDX_S, 1'h0, 1'h0, 1'h1);
      res(16'h01FE, 2'h1);
      p.q = '{8'hFF, 8'h00};
      op(OAG_M_IDX_L, 1'h1, 1'h0, 1'h1);
      res(16'hFF10, 2'h2);
   endtask

   task automatic t_indirect;
      slow = 1'h1;
      p.mem[32] = 8'h9C;
      p.mem[64] = 8'hAB;
      p.mem[65] = 8'hCD;
      p.q = '{8'h20};
      op(OAG_M_IND_S, 1'h0, 1'h0, 1'h1);
      res(16'h009C, 2'h1);
      p.q = '{8'h40};
      op(OAG_M_IND_L, 1'h0, 1'h0, 1'h1);
      res(16'hABCD, 2'h1);
      slow = 1'h0;
   endtask

   task automatic t_relative;
      p.q = '{8'h80};
      op(OAG_M_REL_D, 1'h0, 1'h0, 1'h1);
      res(16'h0F80, 2'h1);
      p.q = '{8'h7F};
      op(OAG_M_REL_D, 1'h0, 1'h0, 1'h1);
      res(16'h107F, 2'h1);
      p.mem[48] = 8'hFE;
      p.q = '{8'h30};
      op(OAG_M_REL_I, 1'h0, 1'h0, 1'h1);
      res(16'h0FFE, 2'h1);
   endtask

   task automatic t_bit;
      slow = 1'h1;
      p.mem[80] = 8'h66;
      p.mem[96] = 8'h44;
      p.q = '{8'h55};
      op(OAG_M_BIT_D, 1'h0, 1'h1, 1'h1);
      res(16'h0055, 2'h1);
      p.q = '{8'h50};
      op(OAG_M_BIT_I, 1'h0, 1'h1, 1'h1);
      res(16'h0066, 2'h1);
      p.q = '{8'h77, 8'h05};
      op(OAG_M_BTR_D, 1'h0, 1'h1, 1'h1);
      res(16'h0077, 2'h2);
      p.q = '{8'h60, 8'h05};
      op(OAG_M_BTR_I, 1'h0, 1'h1, 1'h1);
      res(16'h0044, 2'h2);
      slow = 1'h0;
   endtask

   task automatic t_rmw;
      p.q = '{8'h20};
      op(OAG_M_DIR_S, 1'h0, 1'h1, 1'h1);
      chk(16'(ea_err), 16'h0000);
      p.q = '{8'h20, 8'h00};
      op(OAG_M_DIR_L, 1'h0, 1'h1, 1'h1);
      chk(16'(ea_err), 16'h0001);
      chk(ea_addr, 16'h2000);
      p.q = '{8'h01, 8'h00};
      op(OAG_M_IDX_L, 1'h0, 1'h1, 1'h1);
      chk(16'(ea_err), 16'h0001);
      chk(ea_addr, 16'h01FF);
   endtask

   initial begin
      rst = 1'h1;
      op_valid = 1'h0;
      op_mode = OAG_M_INH;
      op_alt = 1'h0;
      op_rmw = 1'h0;
      idx_pri = 8'h00;
      idx_alt = 8'h00;
      pc_next = 16'h1000;
      slow = 1'h0;
      repeat (16) @(negedge sys_clk);
      rst = 1'h0;
      chk({op_ready, ea_valid, ea_err, ea_is_imm}, 16'h0008);
      t_inh_imm;
      t_direct;
      t_indexed;
      t_indirect;
      t_relative;
      t_bit;
      t_rmw;
      stop_test;
   end

   initial begin
      #100000;
      n_mismatch++;
      stop_test;
   end
endmodule
